// ---- srtu_frontend.sv ----
`timescale 1ns/100ps
`include "srtu_params.svh"
module srtu_frontend import srtu_pkg::*; #(
    parameter int TMO_CYC = `SRTU_TMO_CYC,
    parameter logic [31:0] MAKER = 32'h4e_4f_4e_45, // arbitrary value
    parameter logic [15:0] ITEM = 16'h0a5a, // arbitrary value
    parameter logic [15:0] VERSION = 16'h0100 // arbitrary value
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic line_rx,
    output logic line_tx,
    output logic line_tx_en,
    input wire logic [3:0] address_high_digit_switch,
    input wire logic [3:0] address_low_digit_switch,
    output logic irq,
    output logic exp_bus_active,
    output logic [15:0] exp_out_value,
    output logic [3:0] op_state
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic [2:0] rx_s_q;
    logic [7:0] sw1_q, sw2_q, sw3_q, sw_q, sw_d;
    logic rx_lvl_q, rx_lvl_d;
    logic [3:0] ctrl_baud_q, irq_st_q, irq_mk_q;
    logic [2:0] baud_sel;
    logic [16:0] div;
    logic [7:0] my_addr;
    logic addr_ok;
    srtu_op_t op_q, op_d;
    logic [15:0] bank_q [4];
    logic [15:0] bank_d [4];
    logic reboot, ax_wr;
    logic [7:0] ax_wa;
    logic [31:0] ax_wd;
    logic [15:0] ax_wm;

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        end
        return r;
    endfunction

    // pin synchronisers: a change counts once stages two and three agree
    always_comb begin
        rx_lvl_d = (rx_s_q[1] == rx_s_q[2]) ? rx_s_q[2] : rx_lvl_q;
        sw_d = (sw2_q == sw3_q) ? sw3_q : sw_q;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_s_q <= 3'h7;
            rx_lvl_q <= 1'b1;
            sw1_q <= 8'h00;
            sw2_q <= 8'h00;
            sw3_q <= 8'h00;
            sw_q <= 8'h00;
        end else begin
            rx_s_q <= {rx_s_q[1:0], line_rx};
            rx_lvl_q <= rx_lvl_d;
            sw1_q <= {address_high_digit_switch, address_low_digit_switch};
            sw2_q <= sw1_q;
            sw3_q <= sw2_q;
            sw_q <= sw_d;
        end
    end

    // address from the switches; line speed from the control register, default speed while the switches read zero
    always_comb begin
        my_addr = 8'({4'h0, sw_q[7:4]} * 8'd10) + {4'h0, sw_q[3:0]};
        addr_ok = (my_addr != 8'h00) && (my_addr <= `SRTU_MAX_ADDR);
        baud_sel = (sw_q == 8'h00) ? `SRTU_BAUD_RST : ctrl_baud_q[2:0];
        case (baud_sel)
            3'h0: div = `SRTU_DIV(1200);
            3'h1: div = `SRTU_DIV(2400);
            3'h2: div = `SRTU_DIV(4800);
            3'h3: div = `SRTU_DIV(9600);
            3'h4: div = `SRTU_DIV(19200);
            3'h5: div = `SRTU_DIV(38400);
            3'h6: div = `SRTU_DIV(57600);
            default: div = `SRTU_DIV(115200);
        endcase
    end
    AST_BAUD_DEF: assert property (sw_q == 8'h00 |-> div == `SRTU_DIV(19200))
        else $error("default speed not used");

    // receiver: start, 8 data, even parity, stop
    logic rx_on_q, rx_on_d, rx_stb_q, rx_stb_d, rx_perr_q, rx_perr_d, tx_en_q;
    logic [16:0] rx_cnt_q, rx_cnt_d;
    logic [3:0] rx_bit_q, rx_bit_d;
    logic [9:0] rx_sh_q, rx_sh_d;
    logic [7:0] rx_byte_q, rx_byte_d;
    always_comb begin
        rx_on_d = rx_on_q;
        rx_cnt_d = rx_cnt_q;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_stb_d = 1'b0;
        rx_byte_d = rx_byte_q;
        rx_perr_d = rx_perr_q;
        if (!rx_on_q) begin
            if (!rx_lvl_q && !tx_en_q) begin
                rx_on_d = 1'b1;
                rx_cnt_d = {1'b0, div[16:1]};
                rx_bit_d = 4'h0;
            end
        end else if (rx_cnt_q != 17'h0) begin
            rx_cnt_d = rx_cnt_q - 17'h1;
        end else begin
            rx_cnt_d = div - 17'h1;
            rx_bit_d = rx_bit_q + 4'h1;
            rx_sh_d = {rx_lvl_q, rx_sh_q[9:1]};
            if (rx_bit_q == 4'h0 && rx_lvl_q) rx_on_d = 1'b0; // glitch, not a start
            if (rx_bit_q == 4'ha) begin
                rx_on_d = 1'b0;
                rx_stb_d = 1'b1;
                rx_byte_d = rx_sh_q[8:1];
                rx_perr_d = (^rx_sh_q[9:1]) | !rx_lvl_q;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_on_q <= 1'b0;
            rx_cnt_q <= 17'h0;
            rx_bit_q <= 4'h0;
            rx_sh_q <= 10'h0;
            rx_stb_q <= 1'b0;
            rx_byte_q <= 8'h00;
            rx_perr_q <= 1'b0;
        end else begin
            rx_on_q <= rx_on_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
            rx_stb_q <= rx_stb_d;
            rx_byte_q <= rx_byte_d;
            rx_perr_q <= rx_perr_d;
        end
    end

    // frame assembly, checks and execution against the holding bank
    logic [8:0] idx_q, idx_d;
    logic [15:0] crc_q, crc_d;
    logic err_q, err_d, fend, good, ok, exec, reply, ev_bad;
    logic [23:0] gap_q, gap_d;
    logic [8:0] len_q, len_d;
    srtu_byte_t buf_q [16];
    srtu_byte_t buf_d [16];
    srtu_byte_t fc;
    logic [1:0] bi;
    always_comb begin
        idx_d = idx_q;
        crc_d = crc_q;
        err_d = err_q;
        buf_d = buf_q;
        bank_d = bank_q;
        len_d = len_q;
        ok = 1'b0;
        fc = buf_q[1];
        gap_d = (rx_on_q || rx_stb_q || tx_en_q) ? 24'h0 : gap_q + 24'h1;
        fend = (idx_q != 9'h0) && (gap_q == 24'(div * `SRTU_GAP_BITS));
        good = fend && !err_q && crc_q == 16'h0 && idx_q >= 9'd4;
        case (fc)
            `SRTU_FC_RD, `SRTU_FC_RW: begin
                ok = buf_q[4] == 8'h00 && buf_q[5] != 8'h00 && buf_q[5] <= `SRTU_MAX_Q;
                len_d = 9'd3 + {buf_q[5], 1'b0};
            end
            `SRTU_FC_WR1, `SRTU_FC_WRN: begin
                ok = 1'b1;
                len_d = 9'd6;
            end
            `SRTU_FC_MASK: begin
                ok = 1'b1;
                len_d = 9'd8;
            end
            `SRTU_FC_ID: begin
                ok = buf_q[2] == `SRTU_MEI_ID;
                len_d = `SRTU_ID_LEN;
            end
            default: ok = 1'b0;
        endcase
        exec = good && ok && op_q != ST_BOOT
            && ((buf_q[0] == my_addr && addr_ok) || buf_q[0] == 8'h00);
        reply = exec && buf_q[0] != 8'h00;
        ev_bad = fend && !good;
        if (!exec) len_d = len_q;
        if (rx_stb_q) begin
            if (idx_q < 9'd16) buf_d[idx_q[3:0]] = rx_byte_q;
            idx_d = (idx_q == 9'h1ff) ? idx_q : idx_q + 9'h1;
            crc_d = crc_upd(crc_q, rx_byte_q);
            err_d = err_q | rx_perr_q | (idx_q >= 9'd256);
        end
        if (fend) begin
            idx_d = 9'h0;
            crc_d = 16'hffff;
            err_d = 1'b0;
        end
        for (int k = 0; k < 4; k++) begin
            bi = 2'(k);
            if (ax_wr && ax_wa == `SRTU_OFS_BANK + 8'(4 * k))
                bank_d[k] = (bank_q[k] & ~ax_wm) | (ax_wd[15:0] & ax_wm);
            if (exec) begin
                if (fc == `SRTU_FC_WR1 && buf_q[3][1:0] == bi)
                    bank_d[k] = {buf_q[4], buf_q[5]};
                if (fc == `SRTU_FC_MASK && buf_q[3][1:0] == bi)
                    bank_d[k] = (bank_q[k] & {buf_q[4], buf_q[5]})
                        | ({buf_q[6], buf_q[7]} & ~{buf_q[4], buf_q[5]});
                if (fc == `SRTU_FC_WRN && 2'(bi - buf_q[3][1:0]) < buf_q[5])
                    bank_d[k] = {buf_q[7 + 2 * (2'(bi - buf_q[3][1:0]))],
                        buf_q[8 + 2 * (2'(bi - buf_q[3][1:0]))]};
                if (fc == `SRTU_FC_RW && 2'(bi - buf_q[7][1:0]) < buf_q[9]
                        && 2'(bi - buf_q[7][1:0]) < 2'h2)
                    bank_d[k] = {buf_q[11 + 2 * (1'(bi - buf_q[7][1:0]))],
                        buf_q[12 + 2 * (1'(bi - buf_q[7][1:0]))]};
            end
            if (reboot) bank_d[k] = 16'h0;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 9'h0;
            crc_q <= 16'hffff;
            err_q <= 1'b0;
            gap_q <= 24'h0;
            len_q <= 9'h0;
            buf_q <= '{default: 8'h00};
            bank_q <= '{default: 16'h0};
        end else begin
            idx_q <= idx_d;
            crc_q <= crc_d;
            err_q <= err_d;
            gap_q <= gap_d;
            len_q <= len_d;
            buf_q <= buf_d;
            bank_q <= bank_d;
        end
    end
    AST_BAD_SILENT: assert property (fend && crc_q != 16'h0 |=> !tx_en_q)
        else $error("reply to corrupt frame");
    AST_FOREIGN: assert property (fend && buf_q[0] != 8'h00
        && (buf_q[0] != my_addr || !addr_ok) |=> !tx_en_q)
        else $error("foreign frame answered");
    AST_ADDR_RANGE: assert property (reply |-> my_addr >= 8'h01 && my_addr <= 8'h7f)
        else $error("answered with bad address");

    // reply generator: one byte per index
    logic [8:0] tx_i_q, tx_i_d;
    logic [7:0] gb, tb, j;
    always_comb begin
        j = tx_i_q[7:0] - 8'd3;
        gb = 8'h00;
        case (fc)
            `SRTU_FC_RD, `SRTU_FC_RW: begin
                if (tx_i_q == 9'd0) gb = buf_q[0];
                else if (tx_i_q == 9'd1) gb = fc;
                else if (tx_i_q == 9'd2) gb = {buf_q[5][6:0], 1'b0};
                else if (j[0]) gb = bank_q[2'(buf_q[3][1:0] + j[2:1])][7:0];
                else gb = bank_q[2'(buf_q[3][1:0] + j[2:1])][15:8];
            end
            `SRTU_FC_ID: begin
                case (tx_i_q[4:0])
                    5'd0: gb = buf_q[0];
                    5'd1: gb = fc;
                    5'd2: gb = `SRTU_MEI_ID;
                    5'd3, 5'd4, 5'd14: gb = 8'h01;
                    5'd7: gb = 8'h03;
                    5'd9: gb = 8'h04;
                    5'd10: gb = MAKER[31:24];
                    5'd11: gb = MAKER[23:16];
                    5'd12: gb = MAKER[15:8];
                    5'd13: gb = MAKER[7:0];
                    5'd15, 5'd18, 5'd19: gb = 8'h02;
                    5'd16: gb = ITEM[15:8];
                    5'd17: gb = ITEM[7:0];
                    5'd20: gb = VERSION[15:8];
                    5'd21: gb = VERSION[7:0];
                    default: gb = 8'h00;
                endcase
            end
            default: gb = buf_q[tx_i_q[2:0]];
        endcase
    end

    // transmitter, driver enabled for the whole reply
    logic tx_en_d, tx_q, tx_d, ev_tx;
    logic [16:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_bit_q, tx_bit_d;
    logic [10:0] tx_sh_q, tx_sh_d;
    logic [15:0] tx_crc_q, tx_crc_d;
    always_comb begin
        tx_en_d = tx_en_q;
        tx_i_d = tx_i_q;
        tx_cnt_d = tx_cnt_q;
        tx_bit_d = tx_bit_q;
        tx_sh_d = tx_sh_q;
        tx_crc_d = tx_crc_q;
        ev_tx = 1'b0;
        tb = (tx_i_q < len_q) ? gb : (tx_i_q == len_q) ? tx_crc_q[7:0] : tx_crc_q[15:8];
        if (!tx_en_q) begin
            if (reply) begin
                tx_en_d = 1'b1;
                tx_i_d = 9'h0;
                tx_bit_d = 4'h0;
                tx_crc_d = 16'hffff;
            end
        end else if (tx_bit_q == 4'h0) begin
            if (tx_i_q == len_q + 9'd2) begin
                tx_en_d = 1'b0;
                ev_tx = 1'b1;
            end else begin
                tx_sh_d = {1'b1, ^tb, tb, 1'b0};
                tx_bit_d = 4'd11;
                tx_cnt_d = div - 17'h1;
                tx_i_d = tx_i_q + 9'h1;
                if (tx_i_q < len_q) tx_crc_d = crc_upd(tx_crc_q, tb);
            end
        end else if (tx_cnt_q != 17'h0) begin
            tx_cnt_d = tx_cnt_q - 17'h1;
        end else begin
            tx_sh_d = {1'b1, tx_sh_q[10:1]};
            tx_bit_d = tx_bit_q - 4'h1;
            tx_cnt_d = div - 17'h1;
        end
        tx_d = tx_en_q ? tx_sh_q[0] : 1'b1;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_en_q <= 1'b0;
            tx_i_q <= 9'h0;
            tx_cnt_q <= 17'h0;
            tx_bit_q <= 4'h0;
            tx_sh_q <= 11'h7ff;
            tx_crc_q <= 16'hffff;
            tx_q <= 1'b1;
        end else begin
            tx_en_q <= tx_en_d;
            tx_i_q <= tx_i_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            tx_sh_q <= tx_sh_d;
            tx_crc_q <= tx_crc_d;
            tx_q <= tx_d;
        end
    end
    sequence s_load;
        tx_en_q && tx_bit_q == 4'h0 && tx_i_q != len_q + 9'd2;
    endsequence
    AST_START_BIT: assert property (s_load |=> ##1 !tx_q)
        else $error("no start bit after load");

    // operating states
    logic [15:0] boot_q, boot_d;
    logic [31:0] tmo_q, tmo_d;
    logic ev_tmo;
    always_comb begin
        op_d = op_q;
        boot_d = (op_q == ST_BOOT && !reboot) ? boot_q + 16'h1 : 16'h0; // full boot again
        tmo_d = (op_q == ST_CTRL && !exec) ? tmo_q + 32'h1 : 32'h0;
        ev_tmo = 1'b0;
        case (op_q)
            ST_BOOT: if (boot_q == 16'(`SRTU_BOOT_CYC - 1)) op_d = ST_UNCONF;
            ST_UNCONF: if (exec && (fc == `SRTU_FC_WRN || fc == `SRTU_FC_WR1
                    || fc == `SRTU_FC_MASK)) op_d = ST_CONFIG;
            ST_CONFIG: if (exec && (fc == `SRTU_FC_RD || fc == `SRTU_FC_RW))
                    op_d = ST_CTRL;
            ST_CTRL: begin
                if (exec && fc == `SRTU_FC_WRN) op_d = ST_CONFIG;
                else if (tmo_q == 32'(TMO_CYC - 1)) begin
                    op_d = ST_UNCONF;
                    ev_tmo = 1'b1;
                end
            end
            default: op_d = ST_BOOT;
        endcase
        if (reboot) op_d = ST_BOOT;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_q <= ST_BOOT;
            boot_q <= 16'h0;
            tmo_q <= 32'h0;
            exp_out_value <= 16'h0;
            exp_bus_active <= 1'b0;
        end else begin
            op_q <= op_d;
            boot_q <= boot_d;
            tmo_q <= tmo_d;
            exp_out_value <= (op_q == ST_CTRL) ? bank_q[0] : 16'h0;
            exp_bus_active <= op_q == ST_CTRL;
        end
    end
    sequence s_boot_done;
        op_q == ST_BOOT && boot_q == 16'(`SRTU_BOOT_CYC - 1) && !reboot;
    endsequence
    AST_BOOT_UNCONF: assert property (s_boot_done |=> op_q == ST_UNCONF)
        else $error("boot did not end in unconfigured");
    AST_CTRL_ENTRY: assert property ($rose(op_q == ST_CTRL) |-> $past(op_q) == ST_CONFIG)
        else $error("controlled entered from wrong state");
    AST_TMO: assert property (op_q == ST_CTRL && tmo_q == 32'(TMO_CYC - 1) && !exec
        && !reboot |=> op_q == ST_UNCONF)
        else $error("timeout did not leave controlled");
    AST_REBOOT: assert property (reboot |=> op_q == ST_BOOT && boot_q == 16'h0 ##1 op_q == ST_BOOT)
        else $error("no reboot");
    AST_OUT_ZERO: assert property (op_q != ST_CTRL |=> exp_out_value == 16'h0
        && !exp_bus_active)
        else $error("outputs live before configuration");

    // register slave, write and read channels
    logic aw_f_q, aw_f_d, w_f_q, w_f_d, bv_d, rv_d, awr_d, wr_d, arr_d;
    logic [1:0] br_d, rr_d;
    logic [31:0] rd_d, ax_wd_q;
    logic [7:0] ax_wa_q;
    logic [3:0] ax_ws_q, baud_d, st_d, mk_d;
    always_comb begin
        aw_f_d = aw_f_q | (s_axi_awvalid & s_axi_awready);
        w_f_d = w_f_q | (s_axi_wvalid & s_axi_wready);
        ax_wr = aw_f_q && w_f_q && !s_axi_bvalid;
        ax_wa = ax_wa_q;
        ax_wd = ax_wd_q;
        ax_wm = {{8{ax_ws_q[1]}}, {8{ax_ws_q[0]}}};
        bv_d = s_axi_bvalid & ~s_axi_bready;
        br_d = s_axi_bresp;
        reboot = ax_wr && ax_wa == `SRTU_OFS_CTRL && ax_ws_q[0] && ax_wd[`SRTU_CTRL_REBOOT];
        baud_d = ctrl_baud_q;
        st_d = irq_st_q;
        mk_d = irq_mk_q;
        if (ax_wr) begin
            aw_f_d = 1'b0;
            w_f_d = 1'b0;
            bv_d = 1'b1;
            br_d = (ax_wa[7:5] != 3'h0 || ax_wa[1:0] != 2'h0 || ax_wa == `SRTU_OFS_STAT)
                ? 2'b10 : 2'b00;
            if (ax_ws_q[0] && ax_wa == `SRTU_OFS_CTRL) baud_d = {1'b0, ax_wd[`SRTU_CTRL_BAUD]};
            if (ax_ws_q[0] && ax_wa == `SRTU_OFS_IRQ) st_d = irq_st_q & ~ax_wd[3:0];
            if (ax_ws_q[0] && ax_wa == `SRTU_OFS_MASK) mk_d = ax_wd[3:0];
        end
        st_d = st_d | {ev_tx, ev_tmo, ev_bad, exec}; // set wins over clear
        awr_d = !aw_f_d && !bv_d;
        wr_d = !w_f_d && !bv_d;
        rv_d = s_axi_rvalid & ~s_axi_rready;
        rd_d = s_axi_rdata;
        rr_d = s_axi_rresp;
        if (s_axi_arvalid && s_axi_arready) begin
            rv_d = 1'b1;
            rr_d = 2'b00;
            case (s_axi_araddr)
                `SRTU_OFS_CTRL: rd_d = {28'h0, ctrl_baud_q[2:0], 1'b0};
                `SRTU_OFS_STAT: rd_d = {16'h0, baud_sel, addr_ok, my_addr, op_q};
                `SRTU_OFS_IRQ: rd_d = {28'h0, irq_st_q};
                `SRTU_OFS_MASK: rd_d = {28'h0, irq_mk_q};
                `SRTU_OFS_BANK: rd_d = {16'h0, bank_q[0]};
                8'h14: rd_d = {16'h0, bank_q[1]};
                8'h18: rd_d = {16'h0, bank_q[2]};
                8'h1c: rd_d = {16'h0, bank_q[3]};
                default: begin
                    rd_d = 32'h0;
                    rr_d = 2'b10;
                end
            endcase
        end
        arr_d = !rv_d;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_f_q <= 1'b0;
            w_f_q <= 1'b0;
            ax_wa_q <= 8'h00;
            ax_wd_q <= 32'h0;
            ax_ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
            ctrl_baud_q <= {1'b0, `SRTU_BAUD_RST};
            irq_st_q <= 4'h0;
            irq_mk_q <= 4'h0;
            irq <= 1'b0;
        end else begin
            aw_f_q <= aw_f_d;
            w_f_q <= w_f_d;
            if (s_axi_awvalid && s_axi_awready) ax_wa_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) ax_wd_q <= s_axi_wdata;
            if (s_axi_wvalid && s_axi_wready) ax_ws_q <= s_axi_wstrb;
            s_axi_awready <= awr_d;
            s_axi_wready <= wr_d;
            s_axi_bvalid <= bv_d;
            s_axi_bresp <= br_d;
            s_axi_arready <= arr_d;
            s_axi_rvalid <= rv_d;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rr_d;
            ctrl_baud_q <= baud_d;
            irq_st_q <= st_d;
            irq_mk_q <= mk_d;
            irq <= |(st_d & mk_d);
        end
    end

    assign line_tx = tx_q;
    assign line_tx_en = tx_en_q;
    assign op_state = op_q;
endmodule // srtu_frontend

// ---- srtu_params.svh ----
`ifndef SRTU_PARAMS_SVH
`define SRTU_PARAMS_SVH
`define SRTU_CLK_HZ 100000000
`define SRTU_DIV(baud) (17'(`SRTU_CLK_HZ / (baud)))
`define SRTU_GAP_BITS 39
`define SRTU_BOOT_US 10
`define SRTU_BOOT_CYC (`SRTU_BOOT_US * (`SRTU_CLK_HZ / 1000000))
`define SRTU_TMO_MS 1000
`define SRTU_TMO_CYC (`SRTU_TMO_MS * (`SRTU_CLK_HZ / 1000))
`define SRTU_OFS_CTRL 8'h00
`define SRTU_OFS_STAT 8'h04
`define SRTU_OFS_IRQ 8'h08
`define SRTU_OFS_MASK 8'h0c
`define SRTU_OFS_BANK 8'h10
`define SRTU_CTRL_REBOOT 0
`define SRTU_CTRL_BAUD 3:1
`define SRTU_BAUD_RST 3'h4
`define SRTU_EV_OK 0
`define SRTU_EV_BAD 1
`define SRTU_EV_TMO 2
`define SRTU_EV_TX 3
`define SRTU_MAX_ADDR 8'h7f
`define SRTU_MAX_Q 8'h7d
`define SRTU_FC_RD 8'h03
`define SRTU_FC_WR1 8'h06
`define SRTU_FC_WRN 8'h10
`define SRTU_FC_MASK 8'h16
`define SRTU_FC_RW 8'h17
`define SRTU_FC_ID 8'h2b
`define SRTU_MEI_ID 8'h0e
`define SRTU_ID_LEN 9'd22
`endif

// ---- srtu_pkg.sv ----
package srtu_pkg;
    typedef enum logic [3:0] {
        ST_BOOT = 4'b0001,
        ST_UNCONF = 4'b0010,
        ST_CONFIG = 4'b0100,
        ST_CTRL = 4'b1000
    } srtu_op_t;
    typedef logic [7:0] srtu_byte_t;
endpackage

// ---- srtu_master_model.sv ----
`timescale 1ns/100ps
module srtu_master_model #(
    parameter int BIT = 868
) (
    input wire logic clock,
    output logic line_rx
);
    initial line_rx = 1'b1; // line rests high between frames
    // one character: start, 8 data lsb first, even parity, stop
    task automatic put(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            line_rx <= f[i];
            repeat (BIT) @(posedge clock);
        end
    endtask
    // whole request with crc appended low byte first
    task automatic frame(input logic [7:0] q[6]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
            put(q[i]);
        end
        put(c[7:0]);
        put(c[15:8]);
    endtask
endmodule // srtu_master_model

// ---- test_srtu_frontend.sv ----
`timescale 1ns/100ps
module test_srtu_frontend import srtu_pkg::*;;
    logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, line_rx, line_tx, line_tx_en, irq, act;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] hi, lo, st;
    logic [15:0] outv;
    int errors, tests_run, cyc;
    srtu_frontend #(.TMO_CYC(2000)) i_dut (.clock, .rst_n, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .line_rx,
        .line_tx, .line_tx_en, .address_high_digit_switch(hi), .address_low_digit_switch(lo),
        .irq, .exp_bus_active(act), .exp_out_value(outv), .op_state(st));
    srtu_master_model m (.clock, .line_rx);
    task automatic chk(input logic [31:0] g, e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // axi write: both channels offered together, released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released at the edge where its ready is seen high
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (!bvalid) @(posedge clock);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_boot;
        chk(st, ST_BOOT);
        repeat (1005) @(posedge clock);
        chk(st, ST_UNCONF);
    endtask
    task automatic t_regs;
        rd(8'h04);
        chk(d[15:12], 4'h8);
        lo <= 4'h1;
        wr(8'h00, 32'he);
        rd(8'h04);
        chk(d[15:4], 12'hf01);
        rd(8'h20);
        chk(r, 2'b10);
    endtask
    task automatic t_frame;
        wr(8'h0c, 32'hf);
        m.frame('{8'h01, 8'h06, 8'h00, 8'h00, 8'h12, 8'h34});
        for (int i = 0; i < 40000 && line_tx_en !== 1'b1; i++) @(posedge clock);
        chk(line_tx_en, 1'b1);
        chk(st, ST_CONFIG);
        chk({act, outv}, 17'h0);
        chk(irq, 1'b1);
        // start bit of the reply, then the first data bit of address 01
        repeat (3) @(posedge clock);
        chk(line_tx, 1'b0);
        repeat (1000) @(posedge clock);
        chk(line_tx, 1'b1);
        rd(8'h10);
        chk(d, 32'h1234);
        wr(8'h0c, 32'h0);
        @(posedge clock);
        chk(irq, 1'b0);
        wr(8'h0c, 32'hf);
        @(posedge clock);
        chk(irq, 1'b1);
        wr(8'h08, 32'hf);
        @(posedge clock);
        chk(irq, 1'b0);
    endtask
    task automatic t_reboot;
        wr(8'h00, 32'hf);
        @(posedge clock);
        chk(st, ST_BOOT);
        rd(8'h10);
        chk(d, 32'h0);
        rd(8'h00);
        chk(d, 32'he);
    endtask
    // watchdog on total run length
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 120000) begin
            errors++;
            give_verdict;
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, rst_n} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        hi = '0;
        lo = '0;
        errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        t_boot;
        t_regs;
        t_frame;
        t_reboot;
        give_verdict;
    end
endmodule // test_srtu_frontend
